// File: common/lac_pkg.sv
// Constants, field layouts and mode codes of the light converter control block
package lac_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h01;
  localparam logic [7:0] ADDR_RESULT_LO   = 8'h02;
  localparam logic [7:0] ADDR_RESULT_HI   = 8'h03;
  localparam logic [7:0] ADDR_THR_LO_LSB  = 8'h04;
  localparam logic [7:0] ADDR_THR_LO_MSB  = 8'h05;
  localparam logic [7:0] ADDR_THR_HI_LSB  = 8'h06;
  localparam logic [7:0] ADDR_THR_HI_MSB  = 8'h07;

  // Field positions in control_one
  localparam int MODE_LSB    = 5;
  localparam int MODE_MSB    = 7;
  localparam int INT_BIT     = 2;
  localparam int PERSIST_LSB = 0;
  localparam int PERSIST_MSB = 1;
  // Field positions in control_two
  localparam int RANGE_LSB   = 0;
  localparam int RANGE_MSB   = 1;
  localparam int WIDTH_LSB   = 2;
  localparam int WIDTH_MSB   = 3;

  // Reset values
  localparam logic [7:0]  CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0]  CONTROL_TWO_RST = 8'h00;
  localparam logic [15:0] RESULT_RST      = 16'h0000;
  localparam logic [15:0] THR_LO_RST      = 16'h0000;
  localparam logic [15:0] THR_HI_RST      = 16'hFFFF;
  localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;

  // Persistence counts per persist code
  localparam logic [4:0] PERSIST_N0 = 5'h01;
  localparam logic [4:0] PERSIST_N1 = 5'h04;
  localparam logic [4:0] PERSIST_N2 = 5'h08;
  localparam logic [4:0] PERSIST_N3 = 5'h10;

  // Oscillator cycles per conversion per resolution code
  localparam int CONV_CYC_16 = 65536;
  localparam int CONV_CYC_12 = 4096;
  localparam int CONV_CYC_8  = 256;
  localparam int CONV_CYC_4  = 16;

  // Nominal integration times in ns
  localparam longint INTEG_TIME_16_NS = 105000000;
  localparam longint INTEG_TIME_12_NS = 6500000;
  localparam longint INTEG_TIME_8_NS  = 410000;
  localparam longint INTEG_TIME_4_NS  = 25600;

  // Clock and oscillator divider, rounded down so the longest time is not exceeded
  localparam longint CLK_PERIOD_NS = 20;
  localparam int OSC_DIV = int'(INTEG_TIME_16_NS / (longint'(CONV_CYC_16) * CLK_PERIOD_NS));

  typedef enum logic [2:0] {
    LAC_MODE_OFF      = 3'b000,
    LAC_MODE_VIS_ONCE = 3'b001,
    LAC_MODE_IR_ONCE  = 3'b010,
    LAC_MODE_RSV3     = 3'b011,
    LAC_MODE_RSV4     = 3'b100,
    LAC_MODE_VIS_CONT = 3'b101,
    LAC_MODE_IR_CONT  = 3'b110,
    LAC_MODE_RSV7     = 3'b111
  } lac_mode_t;

endpackage : lac_pkg

// File: verilog/lac_conv_seq.sv
// Oscillator divider and conversion cycle counter
module lac_conv_seq #(
  parameter int DIV_CYC = lac_pkg::OSC_DIV
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Control
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [16:0] cyc_limit,
  // Status
  output logic             conv_done
);

  logic [15:0] div_q;
  logic [16:0] cyc_q;
  logic        osc_tick;

  assign osc_tick = (div_q == 16'(DIV_CYC - 1));

  always_ff @(posedge clk) begin
    if (sys_rst || restart || !run || osc_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Counts oscillator cycles of one conversion and flags its last one
  always_ff @(posedge clk) begin
    if (sys_rst || restart || !run) begin
      cyc_q     <= 17'h0_0000;
      conv_done <= 1'b0;
    end else if (osc_tick) begin
      if (cyc_q >= cyc_limit - 17'h0_0001) begin
        cyc_q     <= 17'h0_0000;
        conv_done <= 1'b1;
      end else begin
        cyc_q     <= cyc_q + 17'h0_0001;
        conv_done <= 1'b0;
      end
    end else begin
      conv_done <= 1'b0;
    end
  end

endmodule : lac_conv_seq

// File: verilog/lac_ctrl.sv
// Control, threshold, persistence and result registers of the light converter
module lac_ctrl #(
  parameter int CYC_16  = lac_pkg::CONV_CYC_16,
  parameter int CYC_12  = lac_pkg::CONV_CYC_12,
  parameter int CYC_8   = lac_pkg::CONV_CYC_8,
  parameter int CYC_4   = lac_pkg::CONV_CYC_4,
  parameter int DIV_CYC = lac_pkg::OSC_DIV
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Byte register port from the serial slave
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  input  wire logic        reg_rd_done,
  output logic      [7:0]  reg_rdata,
  // Analog front end
  input  wire logic [15:0] adc_sample,
  output logic             adc_run,
  output logic             adc_ir_sel,
  output logic      [1:0]  adc_range,
  output logic      [1:0]  adc_width,
  // Interrupt pin, active low
  output logic             int_n
);

  lac_pkg::lac_mode_t mode_q;
  logic [1:0]  persist_q;
  logic        int_flag_q;
  logic [1:0]  range_q;
  logic [1:0]  width_q;
  logic [15:0] result_q;
  logic [15:0] thr_lo_q;
  logic [15:0] thr_hi_q;
  logic [4:0]  out_cnt_q;
  logic [4:0]  out_cnt_d;
  logic [4:0]  persist_n;
  logic [16:0] cyc_limit;
  logic [15:0] width_mask;
  logic [15:0] sample_masked;
  logic        conv_done;
  logic        run;
  logic        restart;
  logic        outside;
  logic        wr_ctl1;
  logic        wr_ctl2;
  logic        clr_int;
  logic        fire;
  logic [7:0]  rd_mux;

  assign wr_ctl1 = reg_wr && (reg_addr == lac_pkg::ADDR_CONTROL_ONE);
  assign wr_ctl2 = reg_wr && (reg_addr == lac_pkg::ADDR_CONTROL_TWO);
  assign clr_int = reg_rd_done && (reg_addr == lac_pkg::ADDR_CONTROL_ONE);

  // Reserved mode codes keep the converter idle
  always_comb begin
    case (mode_q)
      lac_pkg::LAC_MODE_VIS_ONCE,
      lac_pkg::LAC_MODE_IR_ONCE,
      lac_pkg::LAC_MODE_VIS_CONT,
      lac_pkg::LAC_MODE_IR_CONT: run = 1'b1;
      default:                   run = 1'b0;
    endcase
  end

  // A new mode or resolution starts a fresh conversion so no partial count is reported
  assign restart = wr_ctl1 && (reg_wdata[lac_pkg::MODE_MSB:lac_pkg::MODE_LSB] != mode_q)
                 || wr_ctl2
                    && (reg_wdata[lac_pkg::WIDTH_MSB:lac_pkg::WIDTH_LSB] != width_q);

  always_comb begin
    case (width_q)
      2'b00:   cyc_limit = 17'(CYC_16);
      2'b01:   cyc_limit = 17'(CYC_12);
      2'b10:   cyc_limit = 17'(CYC_8);
      default: cyc_limit = 17'(CYC_4);
    endcase
  end

  always_comb begin
    case (width_q)
      2'b00:   width_mask = 16'hFFFF;
      2'b01:   width_mask = 16'h0FFF;
      2'b10:   width_mask = 16'h00FF;
      default: width_mask = 16'h000F;
    endcase
  end

  assign sample_masked = adc_sample & width_mask;

  // Integration time is cycle count times the divided oscillator period
  lac_conv_seq #(
    .DIV_CYC   (DIV_CYC)
  ) u_seq (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .run       (run),
    .restart   (restart),
    .cyc_limit (cyc_limit),
    .conv_done (conv_done)
  );

  // Mode field; single measurements fall back to power-down, a host write wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= lac_pkg::lac_mode_t'(lac_pkg::CONTROL_ONE_RST[lac_pkg::MODE_MSB:
                                                           lac_pkg::MODE_LSB]);
    end else if (wr_ctl1) begin
      mode_q <= lac_pkg::lac_mode_t'(reg_wdata[lac_pkg::MODE_MSB:lac_pkg::MODE_LSB]);
    end else if (conv_done && (mode_q == lac_pkg::LAC_MODE_VIS_ONCE
                               || mode_q == lac_pkg::LAC_MODE_IR_ONCE)) begin
      mode_q <= lac_pkg::LAC_MODE_OFF;
    end
  end

  // Persist field has its own writer, untouched by the return to power-down but loaded by every control_one write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      persist_q <= lac_pkg::CONTROL_ONE_RST[lac_pkg::PERSIST_MSB:lac_pkg::PERSIST_LSB];
    end else if (wr_ctl1) begin
      persist_q <= reg_wdata[lac_pkg::PERSIST_MSB:lac_pkg::PERSIST_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      range_q <= lac_pkg::CONTROL_TWO_RST[lac_pkg::RANGE_MSB:lac_pkg::RANGE_LSB];
      width_q <= lac_pkg::CONTROL_TWO_RST[lac_pkg::WIDTH_MSB:lac_pkg::WIDTH_LSB];
    end else if (wr_ctl2) begin
      range_q <= reg_wdata[lac_pkg::RANGE_MSB:lac_pkg::RANGE_LSB];
      width_q <= reg_wdata[lac_pkg::WIDTH_MSB:lac_pkg::WIDTH_LSB];
    end
  end

  // Threshold bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thr_lo_q <= lac_pkg::THR_LO_RST;
      thr_hi_q <= lac_pkg::THR_HI_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        lac_pkg::ADDR_THR_LO_LSB: thr_lo_q[7:0]  <= reg_wdata;
        lac_pkg::ADDR_THR_LO_MSB: thr_lo_q[15:8] <= reg_wdata;
        lac_pkg::ADDR_THR_HI_LSB: thr_hi_q[7:0]  <= reg_wdata;
        lac_pkg::ADDR_THR_HI_MSB: thr_hi_q[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Result is written only by conversions; host writes never reach it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_q <= lac_pkg::RESULT_RST;
    end else if (conv_done) begin
      result_q <= sample_masked;
    end
  end

  assign outside = (sample_masked <= thr_lo_q) || (sample_masked >= thr_hi_q);

  always_comb begin
    case (persist_q)
      2'b00:   persist_n = lac_pkg::PERSIST_N0;
      2'b01:   persist_n = lac_pkg::PERSIST_N1;
      2'b10:   persist_n = lac_pkg::PERSIST_N2;
      default: persist_n = lac_pkg::PERSIST_N3;
    endcase
  end

  always_comb begin
    out_cnt_d = out_cnt_q;
    if (conv_done) begin
      if (!outside) begin
        out_cnt_d = 5'h00;
      end else if (out_cnt_q < persist_n) begin
        out_cnt_d = out_cnt_q + 5'h01;
      end
    end
  end

  assign fire = conv_done && outside && (out_cnt_d >= persist_n);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_cnt_q <= 5'h00;
    end else begin
      out_cnt_q <= out_cnt_d;
    end
  end

  // A conversion that fires in the clearing cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_flag_q <= lac_pkg::CONTROL_ONE_RST[lac_pkg::INT_BIT];
      int_n      <= 1'b1;
    end else if (fire) begin
      int_flag_q <= 1'b1;
      int_n      <= 1'b0;
    end else if (clr_int) begin
      int_flag_q <= 1'b0;
      int_n      <= 1'b1;
    end
  end

  // Read data; reserved bits read zero
  always_comb begin
    case (reg_addr)
      lac_pkg::ADDR_CONTROL_ONE: begin
        rd_mux = 8'h00;
        rd_mux[lac_pkg::MODE_MSB:lac_pkg::MODE_LSB]       = mode_q;
        rd_mux[lac_pkg::INT_BIT]                          = int_flag_q;
        rd_mux[lac_pkg::PERSIST_MSB:lac_pkg::PERSIST_LSB] = persist_q;
      end
      lac_pkg::ADDR_CONTROL_TWO: begin
        rd_mux = 8'h00;
        rd_mux[lac_pkg::WIDTH_MSB:lac_pkg::WIDTH_LSB] = width_q;
        rd_mux[lac_pkg::RANGE_MSB:lac_pkg::RANGE_LSB] = range_q;
      end
      lac_pkg::ADDR_RESULT_LO:  rd_mux = result_q[7:0];
      lac_pkg::ADDR_RESULT_HI:  rd_mux = result_q[15:8];
      lac_pkg::ADDR_THR_LO_LSB: rd_mux = thr_lo_q[7:0];
      lac_pkg::ADDR_THR_LO_MSB: rd_mux = thr_lo_q[15:8];
      lac_pkg::ADDR_THR_HI_LSB: rd_mux = thr_hi_q[7:0];
      lac_pkg::ADDR_THR_HI_MSB: rd_mux = thr_hi_q[15:8];
      default:                  rd_mux = lac_pkg::UNMAPPED_RDATA;
    endcase
  end

  // Byte is latched at the read request so it stays still while it is shifted out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // Front end controls, registered so they change only on clock edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc_run    <= 1'b0;
      adc_ir_sel <= 1'b0;
      adc_range  <= 2'b00;
      adc_width  <= 2'b00;
    end else begin
      adc_run    <= run;
      adc_ir_sel <= (mode_q == lac_pkg::LAC_MODE_IR_ONCE)
                 || (mode_q == lac_pkg::LAC_MODE_IR_CONT);
      adc_range  <= range_q;
      adc_width  <= width_q;
    end
  end

endmodule : lac_ctrl

// File: sim/lac_ctrl_properties.sv
// Port assertions for the light converter control block
module lac_ctrl_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic       reg_rd_done,
  input wire logic [7:0] reg_rdata,
  // Front end and interrupt
  input wire logic       adc_run,
  input wire logic       adc_ir_sel,
  input wire logic [1:0] adc_range,
  input wire logic [1:0] adc_width,
  input wire logic       int_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Converter idle, so no conversion end can re-set the flag in the same cycle
  sequence s_clear_read;
    reg_rd_done && reg_addr == 8'h00 && !adc_run;
  endsequence
  sequence s_ctl_two_wr;
    reg_wr && reg_addr == 8'h01;
  endsequence

  property p_reset;
    $fell(sys_rst) |-> int_n && reg_rdata == 8'h00 && !adc_run;
  endproperty
  property p_hold;
    !int_n && !(reg_rd_done && reg_addr == 8'h00) |=> !int_n;
  endproperty
  property p_clear;
    s_clear_read |=> int_n;
  endproperty
  property p_width;
    s_ctl_two_wr |-> ##2 adc_width == $past(reg_wdata[3:2], 2);
  endproperty
  property p_range;
    s_ctl_two_wr |-> ##2 adc_range == $past(reg_wdata[1:0], 2);
  endproperty
  property p_rdata;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  property p_unmapped;
    reg_rd && reg_addr > 8'h07 |=> reg_rdata == 8'h00;
  endproperty
  property p_stop;
    reg_wr && reg_addr == 8'h00 && reg_wdata[7:5] == 3'b000 |-> ##2 !adc_run;
  endproperty
  property p_ir_run;
    adc_ir_sel |-> adc_run;
  endproperty

  a_reset: assert property (p_reset) else $error("reset state wrong");
  a_hold: assert property (p_hold) else $error("interrupt released early");
  a_clear: assert property (p_clear) else $error("interrupt not cleared");
  a_width: assert property (p_width) else $error("width not applied");
  a_range: assert property (p_range) else $error("range not applied");
  a_rdata: assert property (p_rdata) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_stop: assert property (p_stop) else $error("power-down ignored");
  a_ir_run: assert property (p_ir_run) else $error("infrared without run");
endmodule : lac_ctrl_properties

bind lac_ctrl lac_ctrl_properties chk_u (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rd, .reg_rd_done, .reg_rdata, .adc_run, .adc_ir_sel, .adc_range, .adc_width, .int_n);

// File: sim/lac_host_model.sv
// Host side of the register port: byte writes and byte reads
module lac_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  output logic            reg_rd_done
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    reg_rd_done = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Address stays put until the transfer end pulse has been taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_rd_done <= 1'b1;
    @(posedge clk);
    reg_rd_done <= 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : lac_host_model

// File: sim/lac_ctrl_tb_top.sv
// Self-checking testbench of the light converter control block
module lac_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RST_TAB [0:8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                            8'hFF, 8'hFF, 8'h00};
  localparam logic [2:0] MODE_TAB [0:4] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h3};
  localparam logic [1:0] RUN_TAB [0:4] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h0};
  localparam int PERS_TAB [0:3] = '{1, 4, 8, 16};
  // Conversion lengths in ticks for resolution codes 00, 01, 10 at the short counts below
  localparam int CYC_TAB [0:2] = '{64, 32, 16};
  // 0x1234 masked to 16, 12 and 8 bits
  localparam logic [15:0] RES_TAB [0:2] = '{16'h1234, 16'h0234, 16'h0034};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] adc_sample = 16'h1234;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
  logic        reg_wr, reg_rd, reg_rd_done, adc_run, adc_ir_sel, int_n;
  logic [1:0]  adc_range, adc_width;
  int          miscompares = 0;
  int          n_checks = 0;
  int          c;

  always #10 clk = ~clk;

  // Short counts: a 4-bit conversion lasts 8 ticks of 2 clocks
  lac_ctrl #(.CYC_16(64), .CYC_12(32), .CYC_8(16), .CYC_4(8), .DIV_CYC(2)) dut_u (.clk,
    .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rd_done, .reg_rdata, .adc_sample,
    .adc_run, .adc_ir_sel, .adc_range, .adc_width, .int_n);
  lac_host_model host_u (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rd_done);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, rv);
    chk({8'h00, rv}, {8'h00, exp});
  endtask : rdchk

  task automatic wait_run_low;
    repeat (2) @(posedge clk);
    c = 0;
    while (adc_run !== 1'b0 && c < 300) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_run_low

  task print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rdchk((i == 8) ? 8'h0F : 8'(i), RST_TAB[i]);
    host_u.wr(8'h01, 8'h0F);
    repeat (2) @(posedge clk);
    chk({14'h0000, adc_width}, 16'h0003);
    chk({14'h0000, adc_range}, 16'h0003);
    rdchk(8'h01, 8'h0F);
    host_u.wr(8'h02, 8'hAA);
    rdchk(8'h02, 8'h00);
    for (int i = 0; i < 5; i++) begin
      host_u.wr(8'h00, {MODE_TAB[i], 5'h00});
      repeat (2) @(posedge clk);
      chk({14'h0000, adc_run, adc_ir_sel}, {14'h0000, RUN_TAB[i]});
      host_u.wr(8'h00, 8'h00);
    end
    // Single 4-bit conversion: 0x1234 keeps only its low nibble
    host_u.wr(8'h00, 8'h20);
    wait_run_low();
    rdchk(8'h02, 8'h04);
    rdchk(8'h03, 8'h00);
    rdchk(8'h00, 8'h00);
    host_u.wr(8'h06, 8'h03);
    host_u.wr(8'h07, 8'h00);
    for (int p = 0; p < 4; p++) begin
      host_u.wr(8'h00, 8'hA0 | 8'(p));
      c = 0;
      while (int_n !== 1'b0 && c < 400) begin
        @(posedge clk);
        c++;
      end
      chk(16'(c >= 16 * PERS_TAB[p] - 3 && c <= 16 * PERS_TAB[p] + 4), 16'h0001);
      host_u.wr(8'h00, 8'(p));
      rdchk(8'h00, 8'h04 | 8'(p));
      // The clear lands on the edge that ends the read, so look one edge later
      @(posedge clk);
      chk({15'h0000, int_n}, 16'h0001);
      rdchk(8'h00, 8'(p));
      // An inside result must clear the running out-of-window count
      host_u.wr(8'h07, 8'hFF);
      host_u.wr(8'h00, 8'h20);
      wait_run_low();
      host_u.wr(8'h07, 8'h00);
    end
    host_u.wr(8'h06, 8'hFF);
    host_u.wr(8'h07, 8'hFF);
    host_u.wr(8'h04, 8'h04);
    host_u.wr(8'h00, 8'h20);
    wait_run_low();
    repeat (2) @(posedge clk);
    chk({15'h0000, int_n}, 16'h0000);
    rdchk(8'h00, 8'h04);
    @(posedge clk);
    chk({15'h0000, int_n}, 16'h0001);
    // Wider resolutions: longer conversions and wider right-aligned results
    for (int w = 0; w < 3; w++) begin
      host_u.wr(8'h01, {4'h0, 2'(w), 2'b11});
      host_u.rd(8'h01, rv);
      chk({8'h00, rv & 8'h0F}, {12'h000, 2'(w), 2'b11});
      host_u.wr(8'h00, 8'h20);
      wait_run_low();
      chk(16'(c), 16'(2 * CYC_TAB[w] + 1));
      rdchk(8'h02, RES_TAB[w][7:0]);
      rdchk(8'h03, RES_TAB[w][15:8]);
    end
    print_verdict();
  end
endmodule : lac_ctrl_tb_top
